// >>> core/quad_dac_device.sv
`timescale 1ns/1ps
// Behaviour
// - Select low: rising clock shifts data, MSB first
// - Chip select ORed with clock; rise clocks too
// - Host ends frame with clock held high
// - Host opens frame without a stray rising edge
// - Output equals low ref plus span times code/4096
// - Load strobe low updates the addressed channel
// - Host shifts nothing while load strobe low
// - Clear low presets all channels, zero or mid
// - Clear ignores chip select and transfers
// - After clear, values hold until next load
// - Address 00..11 selects channels A..D
// - Word order: address, two ignored, code MSB first

// ==========================================================================
// Converter end: serial input register, four channel registers, scaling
// ==========================================================================
module quad_dac_device #(
  parameter int unsigned REF_W = 16
) (
  // Clock and reset
  input  wire logic                                   clock_i,
  input  wire logic                                   reset_i,
  // Serial link
  quad_dac_link_if.dac                                link,
  // Reference levels in output units
  input  wire logic signed [REF_W-1:0]                ref_high_i,
  input  wire logic signed [REF_W-1:0]                ref_low_i,
  // Channel state
  output logic [quad_dac_pkg::NUM_CH-1:0][quad_dac_pkg::CODE_W-1:0] channel_code_o,
  output logic [quad_dac_pkg::NUM_CH-1:0][REF_W-1:0]  channel_level_o,
  output logic [quad_dac_pkg::WORD_W-1:0]             input_word_o,
  output logic [4:0]                                  frame_bits_o,
  output logic                                        preset_active_o
);

  // ========================================================================
  // Elaboration checks
  // ========================================================================
  if (REF_W < 2 || REF_W > 32) begin : g_bad_ref_w
    $error("quad_dac_device: REF_W must lie between 2 and 32");
  end

  // ========================================================================
  // Pin synchronisers
  // ========================================================================
  localparam int unsigned NPIN  = 6;
  localparam int unsigned P_CS  = 0;
  localparam int unsigned P_CLK = 1;
  localparam int unsigned P_DAT = 2;
  localparam int unsigned P_LD  = 3;
  localparam int unsigned P_PR  = 4;
  localparam int unsigned P_SEL = 5;

  logic [NPIN-1:0] sync_first;
  logic [NPIN-1:0] sync_second;
  wire  [NPIN-1:0] pins_raw;

  assign pins_raw = {link.preset_value_select, link.force_preset_n, link.load_output_strobe_n,
                     link.serial_data_in, link.serial_clock, link.chip_select_n};

  // Two stages; the first is read only by the second
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync_first  <= 6'h1b;
      sync_second <= 6'h1b;
    end else begin
      sync_first  <= pins_raw;
      sync_second <= sync_first;
    end
  end

  wire cs_n_s     = sync_second[P_CS];
  wire sclk_s     = sync_second[P_CLK];
  wire serial_data_in_s     = sync_second[P_DAT];
  wire load_n_s   = sync_second[P_LD];
  wire preset_n_s = sync_second[P_PR];
  wire preset_sel = sync_second[P_SEL];

  // ========================================================================
  // Combined shift clock and edge detection
  // ========================================================================
  logic combined_prev;
  logic cs_n_prev;

  // Chip select and clock share one OR; its rising edge is the shift edge
  wire combined_clk = cs_n_s | sclk_s;
  wire shift_edge   = combined_clk & ~combined_prev;
  wire frame_start  = cs_n_prev & ~cs_n_s;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      combined_prev <= 1'b1;
      cs_n_prev     <= 1'b1;
    end else begin
      combined_prev <= combined_clk;
      cs_n_prev     <= cs_n_s;
    end
  end

  // ========================================================================
  // Input shift register
  // ========================================================================
  logic [quad_dac_pkg::WORD_W-1:0] shift_word;
  logic [4:0]                      bit_count;

  // Shifting left keeps the newest sixteen bits, older bits fall off the top
  wire [quad_dac_pkg::WORD_W-1:0] next_shift_word =
    {shift_word[quad_dac_pkg::WORD_W-2:0], serial_data_in_s};

  // Counter saturates so a long frame still reads as over-full
  wire [4:0] next_bit_count = frame_start ? 5'h00 :
                              (shift_edge && bit_count != 5'h1f) ? bit_count + 5'h01 : bit_count;

  // The word is shifted even while the load strobe is low; keeping it quiet is the host's job
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      shift_word <= 16'h0000;
    end else if (shift_edge) begin
      shift_word <= next_shift_word;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bit_count <= 5'h00;
    end else begin
      bit_count <= next_bit_count;
    end
  end

  // ========================================================================
  // Word fields and channel decode
  // ========================================================================
  // First bits in are address, then two ignored, then the code
  wire [quad_dac_pkg::ADDR_W-1:0] word_addr =
    {shift_word[quad_dac_pkg::ADDR_HI_BIT], shift_word[quad_dac_pkg::ADDR_LO_BIT]};
  wire [quad_dac_pkg::CODE_W-1:0] word_code =
    shift_word[quad_dac_pkg::CODE_MSB:quad_dac_pkg::CODE_LSB];

  wire [quad_dac_pkg::NUM_CH-1:0] channel_hit;
  assign channel_hit[0] = (word_addr == quad_dac_pkg::CH_A);
  assign channel_hit[1] = (word_addr == quad_dac_pkg::CH_B);
  assign channel_hit[2] = (word_addr == quad_dac_pkg::CH_C);
  assign channel_hit[3] = (word_addr == quad_dac_pkg::CH_D);

  // ========================================================================
  // Channel registers: preset beats load, load is level sensitive
  // ========================================================================
  wire preset_on = ~preset_n_s;
  wire load_on   = ~load_n_s;
  wire [quad_dac_pkg::CODE_W-1:0] preset_code =
    preset_sel ? quad_dac_pkg::PRESET_MID : quad_dac_pkg::PRESET_ZERO;

  logic [quad_dac_pkg::NUM_CH-1:0][quad_dac_pkg::CODE_W-1:0] channel_code;
  logic [quad_dac_pkg::NUM_CH-1:0][quad_dac_pkg::CODE_W-1:0] next_channel_code;

  // Clear is independent of chip select; a held strobe keeps following the input word
  always_comb begin
    next_channel_code = channel_code;
    for (int ch = 0; ch < quad_dac_pkg::NUM_CH; ch++) begin
      if (preset_on) begin
        next_channel_code[ch] = preset_code;
      end else if (load_on && channel_hit[ch]) begin
        next_channel_code[ch] = word_code;
      end
    end
  end

  // Shift word is untouched by clear, so a later strobe restores it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      channel_code <= {quad_dac_pkg::NUM_CH{quad_dac_pkg::CODE_RESET}};
    end else begin
      channel_code <= next_channel_code;
    end
  end

  // ========================================================================
  // Output scaling: low + span * code / 4096
  // ========================================================================
  wire signed [REF_W:0] ref_span =
    {ref_high_i[REF_W-1], ref_high_i} - {ref_low_i[REF_W-1], ref_low_i};
  wire  [quad_dac_pkg::NUM_CH-1:0][REF_W-1:0] next_level;

  // Code is unsigned, so it gains a zero sign bit before the product
  for (genvar g = 0; g < quad_dac_pkg::NUM_CH; g++) begin : g_scale
    wire signed [REF_W+13:0] product = ref_span * $signed({1'b0, channel_code[g]});
    wire signed [REF_W+13:0] scaled  = product >>> quad_dac_pkg::CODE_SCALE_SHIFT;
    assign next_level[g] = ref_low_i + scaled[REF_W-1:0];
  end

  // ========================================================================
  // Registered outputs; levels and codes update in the same cycle
  // ========================================================================
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      channel_code_o  <= {quad_dac_pkg::NUM_CH{quad_dac_pkg::CODE_RESET}};
      channel_level_o <= '0;
      input_word_o    <= 16'h0000;
      frame_bits_o    <= 5'h00;
      preset_active_o <= 1'b0;
    end else begin
      channel_code_o  <= channel_code;
      channel_level_o <= next_level;
      input_word_o    <= shift_word;
      frame_bits_o    <= bit_count;
      preset_active_o <= preset_on;
    end
  end

endmodule // quad_dac_device

// >>> core/quad_dac_pkg.sv
// ==========================================================================
// Shared constants for the quad converter link and both of its ends
// ==========================================================================
package quad_dac_pkg;

  // ========================================================================
  // Word layout, first bit shifted in is the top bit
  // ========================================================================
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned CODE_W      = 12;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned ADDR_W      = 2;
  localparam int unsigned ADDR_HI_BIT = 15;
  localparam int unsigned ADDR_LO_BIT = 14;
  localparam int unsigned CODE_MSB    = 11;
  localparam int unsigned CODE_LSB    = 0;

  // ========================================================================
  // Channel addresses
  // ========================================================================
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_B = 2'h1;
  localparam logic [1:0] CH_C = 2'h2;
  localparam logic [1:0] CH_D = 2'h3;

  // ========================================================================
  // Preset values and code scale (4096 steps, so a 12 bit shift)
  // ========================================================================
  localparam logic [11:0] PRESET_ZERO      = 12'h000;
  localparam logic [11:0] PRESET_MID       = 12'h800;
  localparam logic [11:0] CODE_RESET       = 12'h000;
  localparam int unsigned CODE_SCALE_SHIFT = 12;

  // ========================================================================
  // Timing, times in ns and counts derived at 125 MHz
  // ========================================================================
  localparam int unsigned CLOCK_PERIOD_NS    = 8;
  localparam int unsigned LINK_HALF_NS       = 80;
  localparam int unsigned LOAD_PULSE_NS      = 80;
  localparam int unsigned LINK_HALF_CYCLES   = (LINK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned LOAD_PULSE_CYCLES  = (LOAD_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES        = 2;

endpackage

// >>> core/quad_dac_link_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Serial link between the controller and the converter
// ==========================================================================
interface quad_dac_link_if;
  logic chip_select_n;
  logic serial_clock;
  logic serial_data_in;
  logic load_output_strobe_n;
  logic force_preset_n;
  logic preset_value_select;

  modport host (
    output chip_select_n,
    output serial_clock,
    output serial_data_in,
    output load_output_strobe_n,
    output force_preset_n,
    output preset_value_select
  );

  modport dac (
    input  chip_select_n,
    input  serial_clock,
    input  serial_data_in,
    input  load_output_strobe_n,
    input  force_preset_n,
    input  preset_value_select
  );
endinterface

// >>> core/quad_dac_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Controller end: makes the serial clock and drives word, load and clear
// ==========================================================================
module quad_dac_host #(
  parameter int unsigned HALF_CYCLES = quad_dac_pkg::LINK_HALF_CYCLES,
  parameter int unsigned LOAD_CYCLES = quad_dac_pkg::LOAD_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // Serial link
  quad_dac_link_if.host    link,
  // Word request
  input  wire logic        send_i,
  input  wire logic [1:0]  send_channel_i,
  input  wire logic [11:0] send_code_i,
  // Load and clear requests
  input  wire logic        load_i,
  input  wire logic        preset_i,
  input  wire logic        preset_mid_i,
  // Status
  output logic             ready_o,
  output logic             done_o
);

  if (HALF_CYCLES < 4 || HALF_CYCLES > 255 || LOAD_CYCLES < 4 || LOAD_CYCLES > 255) begin : g_bad
    $error("quad_dac_host: half period and load pulse need 4 to 255 cycles");
  end

  typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, CLOSE, LOAD} host_state_e;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] LOAD_LAST = 8'(LOAD_CYCLES - 1);

  host_state_e state;
  logic [7:0]  timer;
  logic [4:0]  bits_sent;
  logic [15:0] word;

  // ========================================================================
  // Next word and timing decode
  // ========================================================================
  // Address first, two zero fill bits, then the code
  wire [15:0] next_word = {send_channel_i, 2'b00, send_code_i};
  wire        timer_end = (timer == 8'h00);
  wire        last_bit  = (bits_sent == 5'(quad_dac_pkg::WORD_W));

  // ========================================================================
  // Sequencer
  // ========================================================================
  // Clock idles high so the chip select edges never make a rising edge
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state                     <= IDLE;
      timer                     <= 8'h00;
      bits_sent                 <= 5'h00;
      word                      <= 16'h0000;
      link.chip_select_n        <= 1'b1;
      link.serial_clock         <= 1'b1;
      link.serial_data_in       <= 1'b0;
      link.load_output_strobe_n <= 1'b1;
      ready_o                   <= 1'b0;
      done_o                    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        IDLE: begin
          ready_o <= 1'b1;
          if (send_i) begin
            word               <= next_word;
            bits_sent          <= 5'h00;
            link.chip_select_n <= 1'b0;
            timer              <= HALF_LAST;
            ready_o            <= 1'b0;
            state              <= SETUP;
          end else if (load_i) begin
            link.load_output_strobe_n <= 1'b0;
            timer                     <= LOAD_LAST;
            ready_o                   <= 1'b0;
            state                     <= LOAD;
          end
        end
        SETUP, HIGH: begin
          if (!timer_end) begin
            timer <= timer - 8'h01;
          end else if (last_bit) begin
            link.chip_select_n <= 1'b1;
            timer              <= HALF_LAST;
            state              <= CLOSE;
          end else begin
            link.serial_clock   <= 1'b0;
            link.serial_data_in <= word[15];
            word                <= {word[14:0], 1'b0};
            timer               <= HALF_LAST;
            state               <= LOW;
          end
        end
        LOW: begin
          if (!timer_end) begin
            timer <= timer - 8'h01;
          end else begin
            link.serial_clock <= 1'b1;
            bits_sent         <= bits_sent + 5'h01;
            timer             <= HALF_LAST;
            state             <= HIGH;
          end
        end
        CLOSE: begin
          if (!timer_end) begin
            timer <= timer - 8'h01;
          end else begin
            done_o <= 1'b1;
            state  <= IDLE;
          end
        end
        LOAD: begin
          // No shifting starts until the strobe is back high
          if (!timer_end) begin
            timer <= timer - 8'h01;
          end else begin
            link.load_output_strobe_n <= 1'b1;
            timer                     <= HALF_LAST;
            state                     <= CLOSE;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Clear pins follow the user levels, any time
  // ========================================================================
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      link.force_preset_n      <= 1'b1;
      link.preset_value_select <= 1'b0;
    end else begin
      link.force_preset_n      <= ~preset_i;
      link.preset_value_select <= preset_mid_i;
    end
  end

endmodule // quad_dac_host

// >>> bench/quad_dac_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// Link protocol checker, sees only the wires between the two ends
// ==========================================================================
module quad_dac_monitor #(
  parameter int unsigned HALF_CYCLES = 4,
  parameter int unsigned LOAD_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Link wires
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic load_output_strobe_n,
  input wire logic force_preset_n,
  input wire logic preset_value_select
);
  logic       sclk_q;
  logic [4:0] rise_count;
  logic [7:0] low_run;
  logic [7:0] load_run;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // Rising clock count per frame and run lengths of low levels
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sclk_q     <= 1'b1;
      rise_count <= 5'h00;
      low_run    <= 8'h00;
      load_run   <= 8'h00;
    end else begin
      sclk_q     <= serial_clock;
      rise_count <= chip_select_n ? 5'h00 : rise_count + {4'h0, serial_clock & ~sclk_q};
      low_run    <= serial_clock ? 8'h00 : low_run + 8'h01;
      load_run   <= load_output_strobe_n ? 8'h00 : load_run + 8'h01;
    end
  end

  // ========================================================================
  // Frame boundaries
  // ========================================================================
  sequence s_frame_open;
    $fell(chip_select_n);
  endsequence
  sequence s_frame_close;
    $rose(chip_select_n);
  endsequence

  property p_open_clock_high;
    s_frame_open |-> serial_clock;
  endproperty
  a_open_clock_high: assert property (p_open_clock_high) else $error("frame opened with clock low");
  property p_close_clock_high;
    s_frame_close |-> serial_clock;
  endproperty
  a_close_clock_high: assert property (p_close_clock_high) else $error("frame closed with clock low");
  property p_close_count;
    s_frame_close |-> rise_count == 5'h10;
  endproperty
  a_close_count: assert property (p_close_count) else $error("frame did not hold sixteen edges");
  property p_idle_clock;
    chip_select_n && $past(chip_select_n) |-> serial_clock;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock low outside a frame");
  property p_quiet_in_load;
    !load_output_strobe_n |-> chip_select_n;
  endproperty
  a_quiet_in_load: assert property (p_quiet_in_load) else $error("frame open while load low");
  property p_data_on_low;
    !chip_select_n && $changed(serial_data_in) |-> !serial_clock;
  endproperty
  a_data_on_low: assert property (p_data_on_low) else $error("data moved with clock high");
  property p_half_low;
    $rose(serial_clock) |-> low_run == HALF_CYCLES;
  endproperty
  a_half_low: assert property (p_half_low) else $error("clock low half of wrong length");
  property p_load_width;
    $rose(load_output_strobe_n) |-> load_run == LOAD_CYCLES;
  endproperty
  a_load_width: assert property (p_load_width) else $error("load pulse of wrong length");
endmodule // quad_dac_monitor

// >>> bench/testbench.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench: host joined to one converter, second converter driven by hand
// ==========================================================================
module testbench;
  logic                 clock_i, reset_i, send_i, load_i, preset_i, preset_mid_i;
  logic [1:0]           send_channel_i;
  logic [11:0]          send_code_i;
  logic                 ready_o, done_o, preset_a, preset_b;
  logic [3:0][11:0]     code_a, code_b, exp_code;
  logic [3:0][15:0]     level_a, level_b;
  logic [15:0]          word_a, word_b;
  logic [4:0]           bits_a, bits_b;
  logic signed [15:0]   ref_high_a, ref_low_a, ref_high_b, ref_low_b;
  int                   mismatches, n_tests, c;
  localparam logic [3:0][11:0] CODES = {12'h800, 12'h001, 12'hfff, 12'h5a3};

  quad_dac_link_if link ();
  quad_dac_link_if link_b ();
  quad_dac_host #(.HALF_CYCLES(4), .LOAD_CYCLES(4)) quad_dac_host_inst (.clock_i(clock_i), .reset_i(reset_i),
    .link(link.host), .send_i(send_i), .send_channel_i(send_channel_i), .send_code_i(send_code_i),
    .load_i(load_i), .preset_i(preset_i), .preset_mid_i(preset_mid_i), .ready_o(ready_o), .done_o(done_o));
  quad_dac_device quad_dac_device_inst (.clock_i(clock_i), .reset_i(reset_i), .link(link.dac),
    .ref_high_i(ref_high_a), .ref_low_i(ref_low_a), .channel_code_o(code_a), .channel_level_o(level_a),
    .input_word_o(word_a), .frame_bits_o(bits_a), .preset_active_o(preset_a));
  // Second converter, so that faulty framing can be driven on purpose
  quad_dac_device quad_dac_device_inst2 (.clock_i(clock_i), .reset_i(reset_i), .link(link_b.dac),
    .ref_high_i(ref_high_b), .ref_low_i(ref_low_b), .channel_code_o(code_b), .channel_level_o(level_b),
    .input_word_o(word_b), .frame_bits_o(bits_b), .preset_active_o(preset_b));
  quad_dac_monitor #(.HALF_CYCLES(4), .LOAD_CYCLES(4)) quad_dac_monitor_inst (.clock_i(clock_i),
    .reset_i(reset_i), .chip_select_n(link.chip_select_n), .serial_clock(link.serial_clock),
    .serial_data_in(link.serial_data_in), .load_output_strobe_n(link.load_output_strobe_n),
    .force_preset_n(link.force_preset_n), .preset_value_select(link.preset_value_select));

  // 125 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ========================================================================
  // Shared tasks
  // ========================================================================
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One host request; the strobe is dropped a cycle later, then done is awaited
  task request(input logic is_load, input logic [1:0] ch, input logic [11:0] code);
    int i;
    send_i = ~is_load;
    load_i = is_load;
    send_channel_i = ch;
    send_code_i = code;
    @(negedge clock_i);
    send_i = 1'b0;
    load_i = 1'b0;
    for (i = 0; i < 1000; i++) begin
      @(negedge clock_i);
      if (done_o === 1'b1) break;
    end
    if (i == 1000) mismatches++;
    repeat (3) @(negedge clock_i);
  endtask

  task check_all;
    for (int k = 0; k < 4; k++) begin
      check(code_a[k], exp_code[k]);
      check(level_a[k], 16'h0100 + {4'h0, exp_code[k]});
    end
  endtask

  // Hand-driven frame; close_low ends it by raising select with clock low
  task shift_b(input logic [31:0] w, input int n, input logic close_low);
    // Bench-made link clock: 80 ns halves, a 160 ns period
    for (int i = n - 1; i >= int'(close_low); i--) begin
      link_b.serial_clock = 1'b0;
      link_b.serial_data_in = w[i];
      repeat (quad_dac_pkg::LINK_HALF_CYCLES) @(negedge clock_i);
      link_b.serial_clock = 1'b1;
      repeat (quad_dac_pkg::LINK_HALF_CYCLES) @(negedge clock_i);
    end
    if (close_low) begin
      link_b.serial_clock = 1'b0;
      link_b.serial_data_in = w[0];
      repeat (quad_dac_pkg::LINK_HALF_CYCLES) @(negedge clock_i);
    end
    link_b.chip_select_n = 1'b1;
    repeat (4) @(negedge clock_i);
    link_b.serial_clock = 1'b1;
    link_b.serial_data_in = ~link_b.serial_data_in; // Released line shows no stale bit
    repeat (4) @(negedge clock_i);
  endtask

  task load_b;
    link_b.load_output_strobe_n = 1'b0;
    repeat (4) @(negedge clock_i);
    link_b.load_output_strobe_n = 1'b1;
    repeat (4) @(negedge clock_i);
  endtask

  // Watchdog, well beyond the under two thousand cycles of the sequence
  initial begin
    #100000;
    mismatches++;
    summarize;
  end

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    {send_i, load_i, preset_i, preset_mid_i, send_channel_i, send_code_i} = '0;
    {link_b.chip_select_n, link_b.serial_clock, link_b.load_output_strobe_n, link_b.force_preset_n} = 4'hf;
    {link_b.serial_data_in, link_b.preset_value_select} = 2'b00;
    {ref_high_a, ref_low_a, ref_high_b, ref_low_b} = {16'h1100, 16'h0100, 16'h2000, 16'h0000};
    mismatches = 0;
    n_tests = 0;
    reset_i = 1'b1;
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clock_i);
    exp_code = '0;
    check_all;
    // Every address, each word loaded into its own channel only
    for (c = 0; c < 4; c++) begin
      request(1'b0, 2'(c), CODES[c]);
      check(bits_a, 32'd16);
      check(word_a, {2'(c), 2'b00, CODES[c]});
      request(1'b1, 2'h0, 12'h000);
      check(ready_o, 32'h1);
      exp_code[c] = CODES[c];
      check_all;
    end
    // Midscale and zero presets, held after release until the next load
    preset_mid_i = 1'b1;
    preset_i = 1'b1;
    repeat (8) @(negedge clock_i);
    check(preset_a, 32'h1);
    exp_code = {4{12'h800}};
    check_all;
    preset_i = 1'b0;
    repeat (8) @(negedge clock_i);
    check_all;
    preset_mid_i = 1'b0;
    preset_i = 1'b1;
    repeat (8) @(negedge clock_i);
    exp_code = '0;
    check_all;
    preset_i = 1'b0;
    repeat (8) @(negedge clock_i);
    request(1'b1, 2'h0, 12'h000);
    exp_code[3] = 12'h800;
    check_all;
    // Twenty edges in one frame: only the last sixteen bits count
    link_b.chip_select_n = 1'b0;
    repeat (4) @(negedge clock_i);
    shift_b(32'h000f_b3c5, 20, 1'b0);
    check(word_b, 32'hb3c5);
    check(bits_b, 32'h14);
    load_b;
    check(code_b[2], 32'h3c5);
    check(level_b[2], 32'h078a);
    // Preset in the middle of an open frame, then a select-rise last bit
    link_b.chip_select_n = 1'b0;
    link_b.preset_value_select = 1'b1;
    link_b.force_preset_n = 1'b0;
    repeat (8) @(negedge clock_i);
    for (c = 0; c < 4; c++) check(code_b[c], 32'h800);
    check(preset_b, 32'h1);
    link_b.force_preset_n = 1'b1;
    repeat (4) @(negedge clock_i);
    shift_b(32'h0000_4a5b, 16, 1'b1);
    check(word_b, 32'h4a5b);
    load_b;
    check(code_b[1], 32'ha5b);
    check(code_b[0], 32'h800);
    // Reversed references: a negative span counts down from the low reference
    ref_high_b = 16'h0000;
    ref_low_b = 16'h1000;
    repeat (2) @(negedge clock_i);
    check(level_b[1], 32'h05a5);
    check(level_b[0], 32'h0800);
    summarize;
  end
endmodule // testbench
